// >>> bench/core_model.sv
`timescale 1ns/10ps
module core_model
  import io_space_pkg::*;
(
  input wire logic clk, // Core clock
  output logic req_valid, // Request present
  output op_t req_op, // Operation kind
  output logic [7:0] req_addr, // I/O or data address
  output logic [2:0] req_bit, // Bit number
  output logic [7:0] req_wdata, // Write data
  input wire logic req_ready_ff, // Decoder idle
  input wire logic rsp_valid_ff, // Response pulse
  input wire logic [7:0] rsp_rdata_ff, // Read data
  input wire logic rsp_skip_ff, // Skip result
  input wire logic rsp_error_ff // Rejected
);
  // ****************************************
  // Request driver
  // ****************************************
  initial begin
    req_valid = 1'b0;
    req_op = io_in_op;
    req_addr = 8'h00;
    req_bit = 3'h0;
    req_wdata = 8'h00;
  end

  // Entered at a falling edge; may reissue in the cycle ready returns
  task automatic access(input op_t op, input logic [7:0] addr, input logic [2:0] bitn,
                        input logic [7:0] wd, output logic [7:0] rd, output logic skip,
                        output logic err, output logic ok);
    int n;
    n = 0;
    while (req_ready_ff !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b1;
    req_op = op;
    req_addr = addr;
    req_bit = bitn;
    req_wdata = wd;
    @(posedge clk);
    @(negedge clk);
    // Released address, bit and data flip so stale values cannot pass; the operation is held
    req_valid = 1'b0;
    req_addr = ~addr;
    req_bit = ~bitn;
    req_wdata = ~wd;
    n = 0;
    while (rsp_valid_ff !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    ok = (rsp_valid_ff === 1'b1);
    rd = rsp_rdata_ff;
    skip = rsp_skip_ff;
    err = rsp_error_ff;
  endtask : access
endmodule : core_model

// >>> bench/io_space_access_decoder_test.sv
`timescale 1ns/10ps
module io_space_access_decoder_test import io_space_pkg::*;;
  logic clk, sys_rst, req_valid, req_ready_ff, rsp_valid_ff, rsp_skip_ff, rsp_error_ff;
  logic flag_set_en;
  op_t req_op;
  logic [2:0] req_bit;
  logic [7:0] req_addr, req_wdata, rsp_rdata_ff, flag_set_idx, flag_set_bits;
  logic [7:0] mem_model [256];
  int n_errors, checked, cycles;

  // ****************************************
  // Instances
  // ****************************************
  io_space_access_decoder i_dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata),
    .req_ready_ff(req_ready_ff), .rsp_valid_ff(rsp_valid_ff), .rsp_rdata_ff(rsp_rdata_ff),
    .rsp_skip_ff(rsp_skip_ff), .rsp_error_ff(rsp_error_ff), .flag_set_en(flag_set_en),
    .flag_set_idx(flag_set_idx), .flag_set_bits(flag_set_bits));
  core_model i_core (.clk(clk), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_bit(req_bit), .req_wdata(req_wdata), .req_ready_ff(req_ready_ff),
    .rsp_valid_ff(rsp_valid_ff), .rsp_rdata_ff(rsp_rdata_ff), .rsp_skip_ff(rsp_skip_ff),
    .rsp_error_ff(rsp_error_ff));

  // ****************************************
  // Checking
  // ****************************************
  task automatic finish_test();
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic flag_pulse(input logic [7:0] idx, input logic [7:0] bits);
    flag_set_en = 1'b1;
    flag_set_idx = idx;
    flag_set_bits = bits;
    @(negedge clk);
    flag_set_en = 1'b0;
    flag_set_idx = ~idx;
    flag_set_bits = ~bits;
    mem_model[idx] = mem_model[idx] | bits;
  endtask : flag_pulse

  // Expectation is worked out before the access, model updated after
  task automatic do_op(input logic [3:0] code, input logic [7:0] addr, input logic [2:0] b,
                       input logic [7:0] wd);
    logic [7:0] rd, e_rd, idx;
    logic sk, er, ok, e_sk, e_er, w1c, ld, st;
    op_t op;
    op = op_t'(code);
    ld = op inside {indirect_load_op, direct_load_op, displaced_load_op};
    st = op inside {indirect_store_op, direct_store_op, displaced_store_op};
    idx = (ld || st) ? addr - IO_DATA_OFFSET : addr;
    e_er = (code > 4'hb) || ((op == io_in_op || op == io_out_op) && addr > IO_MAX_ADDR)
        || ((ld || st) && addr < IO_DATA_OFFSET) || (code > 4'h7 && addr > BIT_MAX_ADDR);
    w1c = (idx >= W1C_LO_IDX) && (idx <= W1C_HI_IDX);
    e_rd = 8'h00;
    e_sk = 1'b0;
    if (!e_er && (op == io_in_op || ld)) e_rd = mem_model[idx];
    if (!e_er && op == skip_if_io_bit_set) e_sk = mem_model[idx][b];
    if (!e_er && op == skip_if_io_bit_clear) e_sk = !mem_model[idx][b];
    i_core.access(op, addr, b, wd, rd, sk, er, ok);
    check({7'h00, ok}, 8'h01);
    check(rd, e_rd);
    check({7'h00, sk}, {7'h00, e_sk});
    check({7'h00, er}, {7'h00, e_er});
    if (!e_er && (op == io_out_op || st)) mem_model[idx] = w1c ? mem_model[idx] & ~wd : wd;
    if (!e_er && op == set_io_bit_op) mem_model[idx][b] = !w1c;
    if (!e_er && op == clear_io_bit_op && !w1c) mem_model[idx][b] = 1'b0;
  endtask : do_op

  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    logic [7:0] a;
    sys_rst = 1'b1;
    flag_set_en = 1'b0;
    flag_set_idx = 8'h00;
    flag_set_bits = 8'h00;
    n_errors = 0;
    checked = 0;
    cycles = 0;
    foreach (mem_model[i]) mem_model[i] = REG_RST_VAL;
    void'($urandom(32'hc404));
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    // Status flags: bit ops and writes must spare the neighbours
    flag_pulse(W1C_LO_IDX, 8'hff);
    do_op(set_io_bit_op, W1C_LO_IDX, 3'h3, 8'h00);
    do_op(clear_io_bit_op, W1C_LO_IDX, 3'h5, 8'h00);
    do_op(direct_load_op, W1C_LO_IDX + IO_DATA_OFFSET, 3'h0, 8'h00);
    do_op(io_out_op, W1C_LO_IDX, 3'h0, 8'h05);
    do_op(io_in_op, W1C_LO_IDX, 3'h0, 8'h00);
    // Boundaries of each access path
    do_op(set_io_bit_op, 8'h1f, 3'h7, 8'h00);
    do_op(set_io_bit_op, 8'h20, 3'h7, 8'h00);
    do_op(io_out_op, 8'h3f, 3'h0, 8'h5a);
    do_op(io_out_op, 8'h40, 3'h0, 8'h5a);
    do_op(indirect_load_op, 8'h5f, 3'h0, 8'h00);
    do_op(direct_store_op, 8'hff, 3'h0, 8'hc3);
    do_op(displaced_load_op, 8'hff, 3'h0, 8'h00);
    do_op(indirect_store_op, 8'h1f, 3'h0, 8'h11);
    do_op(io_in_op, 8'h60, 3'h0, 8'h00);
    for (int c = 0; c < 16; c++) do_op(c[3:0], 8'h10, c[2:0], 8'ha5);
    // Random traffic with flag events between accesses
    for (int n = 0; n < 300; n++) begin
      a = $urandom_range(0, 255);
      if ($urandom_range(0, 1) == 0) a = a & 8'h3f;
      if ($urandom_range(0, 7) == 0) flag_pulse(8'h16 + 8'($urandom_range(0, 6)), 8'($urandom));
      do_op(4'($urandom_range(0, 15)), a, 3'($urandom), 8'($urandom));
    end
    finish_test();
  end
endmodule : io_space_access_decoder_test

// >>> common/io_mem_if.sv
`timescale 1ns/10ps
interface io_mem_if;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_mask;
  logic [7:0] wr_data;
  logic [7:0] w1c_bits;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic set_en;
  logic [7:0] set_idx;
  logic [7:0] set_bits;
  modport ctrl (
    output wr_en, wr_idx, wr_mask, wr_data, w1c_bits, rd_idx, set_en, set_idx,
    output set_bits,
    input rd_data
  );
  modport mem (
    input wr_en, wr_idx, wr_mask, wr_data, w1c_bits, rd_idx, set_en, set_idx,
    input set_bits,
    output rd_data
  );
endinterface : io_mem_if

// >>> common/io_space_pkg.sv
package io_space_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] IO_MAX_ADDR = 8'h3f;
  localparam logic [7:0] BIT_MAX_ADDR = 8'h1f;
  localparam logic [7:0] EXT_LO_ADDR = 8'h60;
  localparam logic [7:0] EXT_HI_ADDR = 8'hff;
  // I/O space plus the whole extended region, data addresses 0x20 to 0xff
  localparam int MEM_DEPTH = 224;
  localparam logic [7:0] MEM_LAST_IDX = 8'hdf;
  // I/O indices whose bits are all write-one-to-clear status flags
  localparam logic [7:0] W1C_LO_IDX = 8'h16;
  localparam logic [7:0] W1C_HI_IDX = 8'h1c;
  localparam logic [7:0] REG_RST_VAL = 8'h00;
  localparam int RSP_LATENCY = 3;

  // ****************************************
  // Core operations
  // ****************************************
  typedef enum logic [3:0] {
    io_in_op,
    io_out_op,
    indirect_load_op,
    indirect_store_op,
    direct_load_op,
    direct_store_op,
    displaced_load_op,
    displaced_store_op,
    set_io_bit_op,
    clear_io_bit_op,
    skip_if_io_bit_set,
    skip_if_io_bit_clear
  } op_t;

  function automatic logic is_load_op(input op_t op);
    return op inside {indirect_load_op, direct_load_op, displaced_load_op};
  endfunction : is_load_op

  function automatic logic is_store_op(input op_t op);
    return op inside {indirect_store_op, direct_store_op, displaced_store_op};
  endfunction : is_store_op

  function automatic logic is_bit_op(input op_t op);
    return op inside {set_io_bit_op, clear_io_bit_op, skip_if_io_bit_set,
                      skip_if_io_bit_clear};
  endfunction : is_bit_op

  function automatic logic is_w1c_idx(input logic [7:0] idx);
    return (idx >= W1C_LO_IDX) && (idx <= W1C_HI_IDX);
  endfunction : is_w1c_idx

endpackage : io_space_pkg

// >>> verilog/io_reg_mem.sv
`timescale 1ns/10ps
module io_reg_mem
  import io_space_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Sync reset, high
  io_mem_if.mem m // Access port
);

  logic [7:0] reg_ff [MEM_DEPTH];

  // ****************************************
  // Per-bit update
  // ****************************************
  // Hardware set beats a software clear in the same cycle
  for (genvar r = 0; r < MEM_DEPTH; r++) begin : g_reg
    for (genvar b = 0; b < 8; b++) begin : g_bit
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          reg_ff[r][b] <= REG_RST_VAL[b];
        end else if (m.set_en && m.set_idx == 8'(r) && m.set_bits[b]) begin
          reg_ff[r][b] <= 1'b1;
        end else if (m.wr_en && m.wr_idx == 8'(r) && m.wr_mask[b]) begin
          if (m.w1c_bits[b]) begin
            if (m.wr_data[b]) begin
              reg_ff[r][b] <= 1'b0;
            end
          end else begin
            reg_ff[r][b] <= m.wr_data[b];
          end
        end
      end
    end
  end

  // ****************************************
  // Registered read
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      m.rd_data <= 8'h00;
    end else if (m.rd_idx <= MEM_LAST_IDX) begin
      m.rd_data <= reg_ff[m.rd_idx];
    end else begin
      m.rd_data <= 8'h00;
    end
  end

endmodule : io_reg_mem

// >>> verilog/io_space_access_decoder.sv
// Operation
// - Bit set and clear only at I/O addresses 0x00-0x1F; reject elsewhere.
// - Bit test with skip result allowed in the bit-addressable range.
// - Writing one clears a status flag; writing zero leaves it.
// - Bit set or clear changes only the addressed bit.
// - I/O in and out use I/O addresses 0x00 through 0x3F.
// - Load and store see I/O address plus 0x20.
// - Extended region 0x60-0xFF reachable by load and store only.
`timescale 1ns/10ps
module io_space_access_decoder
  import io_space_pkg::*;
(
  input wire logic clk, // Core clock, 25 MHz
  input wire logic sys_rst, // Sync reset, high
  input wire logic req_valid, // Core request
  input wire op_t req_op, // Operation kind
  input wire logic [7:0] req_addr, // I/O or data address
  input wire logic [2:0] req_bit, // Bit number for bit ops
  input wire logic [7:0] req_wdata, // Write data
  output logic req_ready_ff, // Idle, request taken
  output logic rsp_valid_ff, // Response pulse
  output logic [7:0] rsp_rdata_ff, // Read data
  output logic rsp_skip_ff, // Skip next instruction
  output logic rsp_error_ff, // Access rejected
  input wire logic flag_set_en, // Peripheral flag event
  input wire logic [7:0] flag_set_idx, // I/O index of flag register
  input wire logic [7:0] flag_set_bits // Flags to set
);

  typedef enum logic [1:0] {st_idle, st_access, st_capture} state_t;

  state_t state_ff;
  op_t op_ff;
  logic [7:0] idx_ff;
  logic [2:0] bit_ff;
  logic [7:0] wdata_ff;
  logic err_ff;
  logic [7:0] nxt_idx;
  logic nxt_err;
  logic accept;
  logic [7:0] bit_sel;

  io_mem_if mi ();

  io_reg_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .m(mi.mem)
  );

  assign accept = req_valid && req_ready_ff;
  assign bit_sel = 8'h01 << bit_ff;

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    nxt_idx = req_addr;
    nxt_err = 1'b1;
    unique case (req_op)
      io_in_op, io_out_op: begin
        // Extended region has no I/O-instruction address
        nxt_err = req_addr > IO_MAX_ADDR;
      end
      indirect_load_op, indirect_store_op, direct_load_op,
      direct_store_op, displaced_load_op, displaced_store_op: begin
        // Below the offset is the core register file, not ours
        nxt_idx = req_addr - IO_DATA_OFFSET;
        nxt_err = req_addr < IO_DATA_OFFSET;
      end
      set_io_bit_op, clear_io_bit_op,
      skip_if_io_bit_set, skip_if_io_bit_clear: begin
        nxt_err = req_addr > BIT_MAX_ADDR;
      end
      default: begin
        nxt_err = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Sequencing
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= st_idle;
      req_ready_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        st_idle: begin
          if (accept) begin
            state_ff <= st_access;
            req_ready_ff <= 1'b0;
          end
        end
        st_access: begin
          state_ff <= st_capture;
        end
        st_capture: begin
          state_ff <= st_idle;
          req_ready_ff <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_ff <= io_in_op;
      idx_ff <= 8'h00;
      bit_ff <= 3'h0;
      wdata_ff <= 8'h00;
      err_ff <= 1'b0;
    end else if (accept) begin
      op_ff <= req_op;
      idx_ff <= nxt_idx;
      bit_ff <= req_bit;
      wdata_ff <= req_wdata;
      err_ff <= nxt_err;
    end
  end

  // ****************************************
  // Register file access
  // ****************************************
  always_comb begin
    mi.rd_idx = idx_ff;
    mi.wr_idx = idx_ff;
    mi.wr_en = 1'b0;
    mi.wr_mask = 8'hff;
    mi.wr_data = wdata_ff;
    mi.w1c_bits = is_w1c_idx(idx_ff) ? 8'hff : 8'h00;
    if (state_ff == st_access && !err_ff) begin
      if (op_ff == io_out_op || is_store_op(op_ff)) begin
        mi.wr_en = 1'b1;
      end else if (op_ff == set_io_bit_op) begin
        // A one only on the chosen bit, so sibling flags survive
        mi.wr_en = 1'b1;
        mi.wr_mask = bit_sel;
        mi.wr_data = bit_sel;
      end else if (op_ff == clear_io_bit_op) begin
        // On a flag register this writes zero and so changes nothing
        mi.wr_en = 1'b1;
        mi.wr_mask = bit_sel;
        mi.wr_data = 8'h00;
      end
    end
  end

  assign mi.set_en = flag_set_en;
  assign mi.set_idx = flag_set_idx;
  assign mi.set_bits = flag_set_bits;

  // ****************************************
  // Response
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 8'h00;
      rsp_skip_ff <= 1'b0;
      rsp_error_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= state_ff == st_capture;
      if (state_ff == st_capture) begin
        rsp_error_ff <= err_ff;
        rsp_rdata_ff <= 8'h00;
        rsp_skip_ff <= 1'b0;
        if (!err_ff && (op_ff == io_in_op || is_load_op(op_ff))) begin
          rsp_rdata_ff <= mi.rd_data;
        end
        if (!err_ff && op_ff == skip_if_io_bit_set) begin
          rsp_skip_ff <= mi.rd_data[bit_ff];
        end
        if (!err_ff && op_ff == skip_if_io_bit_clear) begin
          rsp_skip_ff <= !mi.rd_data[bit_ff];
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_bit_range_reject: assert property (
    accept && is_bit_op(req_op) && req_addr > BIT_MAX_ADDR
    |-> ##3 rsp_valid_ff && rsp_error_ff)
    else $error("bit op above 0x1f not rejected");

  a_bit_range_take: assert property (
    accept && is_bit_op(req_op) && req_addr <= BIT_MAX_ADDR
    |-> ##3 rsp_valid_ff && !rsp_error_ff)
    else $error("bit op in range rejected");

  a_skip_only_test: assert property (
    rsp_valid_ff && rsp_skip_ff |-> !rsp_error_ff
      && $past(op_ff) inside {skip_if_io_bit_set, skip_if_io_bit_clear})
    else $error("skip raised by a non-test op");

  a_clear_writes_zero: assert property (
    mi.wr_en && op_ff == clear_io_bit_op |-> mi.wr_data == 8'h00)
    else $error("bit clear drove a one");

  a_single_bit_mask: assert property (
    mi.wr_en && op_ff inside {set_io_bit_op, clear_io_bit_op}
    |-> $onehot(mi.wr_mask) && mi.wr_mask == (8'h01 << bit_ff))
    else $error("bit op wrote more than one bit");

  a_set_one_hot_data: assert property (
    mi.wr_en && op_ff == set_io_bit_op |-> mi.wr_data == mi.wr_mask)
    else $error("bit set data not one-hot on mask");

  a_io_range: assert property (
    accept && req_op inside {io_in_op, io_out_op}
    |-> ##3 rsp_valid_ff && (rsp_error_ff == ($past(req_addr, 3) > IO_MAX_ADDR)))
    else $error("I/O instruction range wrong");

  a_data_offset: assert property (
    accept && (is_load_op(req_op) || is_store_op(req_op))
      && req_addr >= IO_DATA_OFFSET
    |=> idx_ff == $past(req_addr) - IO_DATA_OFFSET && !err_ff)
    else $error("data-space offset not removed");

  a_ext_no_write: assert property (
    accept && req_op == io_out_op && req_addr >= EXT_LO_ADDR
    |-> ##1 !mi.wr_en ##2 rsp_error_ff)
    else $error("extended region written by I/O op");

  a_busy_window: assert property (
    accept |=> !req_ready_ff [*2] ##1 req_ready_ff)
    else $error("ready timing wrong");

  c_skip_taken: cover property (rsp_valid_ff && rsp_skip_ff);
  c_flag_clear: cover property (mi.wr_en && op_ff == set_io_bit_op
                                && is_w1c_idx(idx_ff));
  c_ext_store: cover property (accept && is_store_op(req_op)
                               && req_addr >= EXT_LO_ADDR);
  c_rejected: cover property (rsp_valid_ff && rsp_error_ff);

endmodule : io_space_access_decoder
